// file: core/blc_top.sv
`timescale 1ns/100ps
// Function
// - emit the programmed number of dark rows, 1 to 255, at each frame start
// - global shutter dark rows are 80 kernels long
// - rolling shutter dark rows take the active window line length
// - skip bit blanks first dark row and keeps it out of calibration
// - auto mode derives offsets from dark samples and corrects image pixels
// - manual mode uses the manual offset magnitude and sign instead
// - dark pixels always leave raw, never compensated
// - manual mode adds or subtracts the 9-bit magnitude to each image pixel
// - manual mode applies one identical offset on every channel
// - auto mode with magnitude all ones freezes the correction factors
// - any other magnitude in auto mode keeps the algorithm running
// - unfrozen auto mode recalculates correction factors every frame
// - sign zero adds the manual offset, sign one subtracts it
// - sign bit ignored while auto calibration is enabled
// - one offset per kernel column, 64 in all, applied per column
// - dark samples averaged over two to the power of the exponent field
// - error flag set when requested samples exceed those available
// ====================================================
// operation
// - frame start latches the row count and skip bit
// - a row count of zero runs as one row
// - dark rows follow, one pixel per accepted beat
// - dark pixels leave raw with the dark tag set
// - a skipped first row is taken but dropped
// - each column sums its first 2^n used samples
// - a column offset is its sum shifted right by n
// - a calc cycle after the last dark pixel loads offsets in auto mode
// - that cycle also sets or clears the error flag
// - image pixels are then corrected per column
// - auto mode subtracts the column offset
// - manual mode adds or subtracts one magnitude
// - the freeze code keeps the offsets of the last update
// - results clamp to the pixel code range
// ====================================================
// timing
// - frame start is a one-cycle pulse
// - register writes act at the next edge
// - read data follows one cycle after its strobe
// - read data holds until the next read
// - an accepted pixel leaves one cycle later at best
// - ready drops in the calc cycle and, outside a blanked row, when full
// - blanked pixels are still acknowledged
// - after reset: image phase, zero offsets
// ====================================================
// limitations
// - image lines must be whole kernels of 64 pixels
// - no pixel may be offered with frame start
// - frame start in mid-row abandons that row
// - row count and skip act from the next frame start
// - the offset word acts at once, even mid-frame
// - frozen offsets hold, the error flag still updates
// - one datapath, so only bit 0 of the error word
// - the error word ignores writes
// - unmapped addresses read as zero
// - sums hold 128 full-scale samples, the largest n
// - rolling shutter row length comes from the window input
// - no interrupt: software polls the error word

module blc_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [blc_pkg::BLC_ADDR_W-1:0] reg_addr_in,
  input wire logic [blc_pkg::BLC_DATA_W-1:0] reg_wdata_in,
  output logic [blc_pkg::BLC_DATA_W-1:0] reg_rdata_out,
  // frame and readout mode
  input wire logic frame_start_in,
  input wire logic global_shutter_in,
  input wire logic [blc_pkg::BLC_ROW_W-1:0] line_kernels_in,
  // pixels from the column converters
  input wire logic [blc_pkg::BLC_PIX_W-1:0] pix_data_in,
  input wire logic pix_valid_in,
  output logic pix_ready_out,
  // pixels toward the serial outputs
  output logic [blc_pkg::BLC_PIX_W-1:0] pix_data_out,
  output logic pix_dark_out,
  output logic pix_valid_out,
  input wire logic pix_ready_in,
  // status
  output logic dark_cal_error_flags_out
);
  import blc_pkg::*;

  // ====================================================
  // state
  typedef struct packed {
    // frame sequencing
    blc_phase_e phase;
    logic [BLC_ROW_W-1:0] rows;
    logic skip;
    logic [BLC_ROW_W-1:0] row;

    // position in the row and the image column
    logic [BLC_PCNT_W-1:0] pcnt;
    logic [BLC_COL_W-1:0] col;

    // per-column sums, sample counts and offsets
    logic [BLC_COLS-1:0][BLC_ACC_W-1:0] acc;
    logic [BLC_COLS-1:0][BLC_CNT_W-1:0] cnt;
    logic [BLC_COLS-1:0][BLC_PIX_W-1:0] ofs;

    // programmable and status words
    logic [BLC_DATA_W-1:0] black_offset_ctrl_reg;
    logic [BLC_DATA_W-1:0] black_line_config_reg;
    logic [BLC_DATA_W-1:0] dark_filter_ctrl_reg;
    logic [BLC_DATA_W-1:0] dark_cal_error_flags_reg;
    // read data, held until the next read
    logic [BLC_DATA_W-1:0] rdata;
  } blc_state_s;

  blc_state_s s_reg;
  blc_state_s s_next;

  // ====================================================
  // decoded fields
  logic auto_en;
  logic [8:0] man_mag;
  logic man_sub;
  logic freeze;
  logic [2:0] smp_exp;
  logic [BLC_CNT_W-1:0] need;
  logic [BLC_ROW_W-1:0] lines_cfg;

  // fields read live from the flops, so mode changes act at once
  assign auto_en = s_reg.black_offset_ctrl_reg[BLC_AUTO_BIT];
  assign man_mag = s_reg.black_offset_ctrl_reg[BLC_MAG_MSB:BLC_MAG_LSB];
  assign man_sub = s_reg.black_offset_ctrl_reg[BLC_SIGN_BIT];
  assign freeze = auto_en && (man_mag == BLC_MAG_FREEZE);
  assign smp_exp = s_reg.dark_filter_ctrl_reg[BLC_SMP_MSB:BLC_SMP_LSB];
  assign need = BLC_CNT_W'(1) << smp_exp;
  assign lines_cfg = s_reg.black_line_config_reg[BLC_LINES_MSB:BLC_LINES_LSB];

  // ====================================================
  // dark row geometry
  logic [BLC_ROW_W-1:0] kernels;
  logic [BLC_PCNT_W-1:0] row_last;

  // kernels of 64 pixels; rolling shutter follows the window
  assign kernels = global_shutter_in ? BLC_GS_KERNELS : line_kernels_in;
  // index of the last pixel in a dark row
  assign row_last = {kernels, BLC_COL_W'(0)} - BLC_PCNT_W'(1);

  // ====================================================
  // per-column filter results
  logic [BLC_COLS-1:0] col_short;
  logic [BLC_COLS-1:0][BLC_PIX_W-1:0] ofs_calc;

  // average is sum over the first 2^n samples of the column
  for (genvar i = 0; i < BLC_COLS; i++) begin : g_col
    logic [BLC_ACC_W-1:0] mean;
    assign mean = s_reg.acc[i] >> smp_exp;
    assign ofs_calc[i] = mean[BLC_PIX_W-1:0];
    // a column still short of samples feeds the error flag
    assign col_short[i] = s_reg.cnt[i] < need;
  end

  // ====================================================
  // pixel datapath
  logic is_dark;
  logic blank;
  logic fire;
  logic [BLC_COL_W-1:0] col_idx;
  logic signed [BLC_RES_W-1:0] corr;
  logic signed [BLC_RES_W-1:0] sum;
  logic [BLC_PIX_W-1:0] comp;
  logic row_end;
  logic smp_use;

  // stream toward the buffer; the dark tag rides in the top bit
  blc_stream_if #(.WIDTH(BLC_FIFO_W)) push_if ();

  assign is_dark = s_reg.phase == BLC_DARK;
  // with the skip bit set, the first dark row is swallowed, not sent
  assign blank = is_dark && s_reg.skip && (s_reg.row == '0);
  assign smp_use = !blank;
  assign col_idx = is_dark ? s_reg.pcnt[BLC_COL_W-1:0] : s_reg.col;
  assign row_end = s_reg.pcnt == row_last;

  // correction term: per column in auto, one shared value in manual
  always_comb begin
    if (auto_en) begin
      corr = -$signed({2'b00, s_reg.ofs[col_idx]});
    // the sign bit matters only in manual mode
    end else if (man_sub) begin
      corr = -$signed({3'b000, man_mag});
    end else begin
      corr = $signed({3'b000, man_mag});
    end
  end

  // clamp instead of wrapping so dark skies never turn white
  assign sum = $signed({2'b00, pix_data_in}) + corr;
  // saturate to the pixel code range
  always_comb begin
    if (sum < 0) begin
      comp = '0;
    end else if (sum > BLC_PIX_MAX) begin
      comp = BLC_PIX_MAX[BLC_PIX_W-1:0];
    end else begin
      comp = sum[BLC_PIX_W-1:0];
    end
  end

  // dark samples leave raw and tagged
  assign push_if.data = {is_dark, is_dark ? pix_data_in : comp};
  assign push_if.valid = pix_valid_in && (s_reg.phase != BLC_CALC) && !blank;
  // a stalled receiver stalls the converters through the buffer
  assign pix_ready_out = (s_reg.phase != BLC_CALC) && (blank || push_if.ready);
  assign fire = pix_valid_in && pix_ready_out;

  // ====================================================
  // output buffer
  // sixteen words absorb short stalls of the receiver
  blc_fifo #(.WIDTH(BLC_FIFO_W), .DEPTH(BLC_FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .wr(push_if.snk),
    .data_out({pix_dark_out, pix_data_out}),
    .valid_out(pix_valid_out),
    .ready_in(pix_ready_in)
  );

  // ====================================================
  // register outputs
  assign reg_rdata_out = s_reg.rdata;
  assign dark_cal_error_flags_out = s_reg.dark_cal_error_flags_reg[BLC_ERR_BIT];

  // ====================================================
  // next-state logic
  always_comb begin
    s_next = s_reg;

    // register writes, reserved bits held at zero
    // the error word is read-only, so writes to it are dropped
    if (reg_wr_in) begin
      case (reg_addr_in)
        BLC_ADDR_OFS: s_next.black_offset_ctrl_reg = reg_wdata_in & BLC_OFS_MASK;
        BLC_ADDR_LINES: s_next.black_line_config_reg = reg_wdata_in & BLC_LINES_MASK;
        BLC_ADDR_FILT: s_next.dark_filter_ctrl_reg = reg_wdata_in & BLC_FILT_MASK;
        default: s_next.rdata = s_reg.rdata;
      endcase
    end

    // register reads, unmapped addresses read zero
    // a read with a write in one cycle returns the old word
    if (reg_rd_in) begin
      case (reg_addr_in)
        BLC_ADDR_OFS: s_next.rdata = s_reg.black_offset_ctrl_reg;
        BLC_ADDR_LINES: s_next.rdata = s_reg.black_line_config_reg;
        BLC_ADDR_FILT: s_next.rdata = s_reg.dark_filter_ctrl_reg;
        BLC_ADDR_ERR: s_next.rdata = s_reg.dark_cal_error_flags_reg;
        default: s_next.rdata = '0;
      endcase
    end

    // row count and skip latched at frame start; the other fields act at once, even mid-frame
    if (frame_start_in) begin
      s_next.phase = BLC_DARK;
      s_next.rows = (lines_cfg == '0) ? BLC_ROW_W'(1) : lines_cfg;
      s_next.skip = s_reg.black_line_config_reg[BLC_SKIP_BIT];
      s_next.row = '0;
      s_next.pcnt = '0;
      s_next.col = '0;
      // offsets are kept, the sums and sample counts restart
      s_next.acc = '0;
      s_next.cnt = '0;
    end else begin
      case (s_reg.phase)
        BLC_DARK: begin
          if (fire) begin
            // accumulate until the column holds its 2^n samples
            if (smp_use && col_short[col_idx]) begin
              s_next.acc[col_idx] = s_reg.acc[col_idx] + BLC_ACC_W'(pix_data_in);
              s_next.cnt[col_idx] = s_reg.cnt[col_idx] + BLC_CNT_W'(1);
            end
            // row boundary: restart the position and count the row
            if (row_end) begin
              s_next.pcnt = '0;
              if (s_reg.row == s_reg.rows - BLC_ROW_W'(1)) begin
                // last dark row done, offsets follow next cycle
                s_next.phase = BLC_CALC;
              end else begin
                s_next.row = s_reg.row + BLC_ROW_W'(1);
              end
            end else begin
              s_next.pcnt = s_reg.pcnt + BLC_PCNT_W'(1);
            end
          end
        end

        BLC_CALC: begin
          // one idle cycle so the last sample is counted
          s_next.dark_cal_error_flags_reg[BLC_ERR_BIT] = |col_short;
          // a frozen set keeps the last offsets
          if (auto_en && !freeze) begin
            s_next.ofs = ofs_calc;
          end
          s_next.phase = BLC_IMAGE;
          s_next.col = '0;
        end

        BLC_IMAGE: begin
          // image lines are whole kernels, so columns simply wrap
          if (fire) begin
            s_next.col = s_reg.col + BLC_COL_W'(1);
          end
        end

        // unused codes fall back to the image phase
        default: s_next.phase = BLC_IMAGE;
      endcase
    end
  end

  // ====================================================
  // state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_reg <= '{
        // idle in the image phase with zero offsets
        phase: BLC_IMAGE,
        // programmable words at their power-on values
        black_offset_ctrl_reg: BLC_OFS_RST,
        black_line_config_reg: BLC_LINES_RST,
        dark_filter_ctrl_reg: BLC_FILT_RST,
        default: '0
      };
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// file: core/blc_pkg.sv
// ====================================================
// black-level calibration constants
package blc_pkg;
  // ====================================================
  // widths and sizes
  localparam int BLC_PIX_W = 10;
  localparam int BLC_COLS = 64;
  localparam int BLC_COL_W = 6;
  localparam int BLC_ACC_W = 17;
  localparam int BLC_CNT_W = 8;
  localparam int BLC_ROW_W = 8;
  localparam int BLC_PCNT_W = 14;
  localparam int BLC_ADDR_W = 9;
  localparam int BLC_DATA_W = 16;
  localparam int BLC_FIFO_DEPTH = 16;
  localparam int BLC_FIFO_W = BLC_PIX_W + 1;
  localparam int BLC_RES_W = 12;

  // ====================================================
  // register addresses
  localparam logic [BLC_ADDR_W-1:0] BLC_ADDR_FILT = 9'h080;
  localparam logic [BLC_ADDR_W-1:0] BLC_ADDR_OFS = 9'h081;
  localparam logic [BLC_ADDR_W-1:0] BLC_ADDR_ERR = 9'h088;
  localparam logic [BLC_ADDR_W-1:0] BLC_ADDR_LINES = 9'h0C5;

  // ====================================================
  // field positions
  localparam int BLC_AUTO_BIT = 0;
  localparam int BLC_MAG_LSB = 1;
  localparam int BLC_MAG_MSB = 9;
  localparam int BLC_SIGN_BIT = 10;
  localparam int BLC_LINES_LSB = 0;
  localparam int BLC_LINES_MSB = 7;
  localparam int BLC_SKIP_BIT = 8;
  localparam int BLC_SMP_LSB = 8;
  localparam int BLC_SMP_MSB = 10;
  localparam int BLC_ERR_BIT = 0;

  // ====================================================
  // reset values and writable masks
  localparam logic [BLC_DATA_W-1:0] BLC_OFS_RST = 16'h0001;
  localparam logic [BLC_DATA_W-1:0] BLC_LINES_RST = 16'h0108;
  localparam logic [BLC_DATA_W-1:0] BLC_FILT_RST = 16'h0300;
  localparam logic [BLC_DATA_W-1:0] BLC_OFS_MASK = 16'h07FF;
  localparam logic [BLC_DATA_W-1:0] BLC_LINES_MASK = 16'h01FF;
  localparam logic [BLC_DATA_W-1:0] BLC_FILT_MASK = 16'h0700;

  // ====================================================
  // special values
  localparam logic [8:0] BLC_MAG_FREEZE = 9'h1FF;
  localparam logic [BLC_ROW_W-1:0] BLC_GS_KERNELS = 8'h50;
  localparam logic signed [BLC_RES_W-1:0] BLC_PIX_MAX = 12'sh3FF;

  // frame phases
  typedef enum logic [1:0] {
    BLC_DARK,
    BLC_CALC,
    BLC_IMAGE
  } blc_phase_e;
endpackage

// file: core/blc_stream_if.sv
`timescale 1ns/100ps
// ====================================================
// valid/ready word stream between the datapath and its buffer
interface blc_stream_if #(parameter int WIDTH = 11) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: core/blc_fifo.sv
`timescale 1ns/100ps
// ====================================================
// output buffer, flip-flop storage indexed by pointers
module blc_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // fill side
  blc_stream_if.snk wr,
  // drain side
  output logic [WIDTH-1:0] data_out,
  output logic valid_out,
  input wire logic ready_in
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } blc_fifo_s;

  blc_fifo_s s_reg;
  blc_fifo_s s_next;
  logic push;
  logic pop;

  // ====================================================
  // handshakes, full and empty straight from the count
  assign wr.ready = s_reg.cnt < (AW+1)'(DEPTH);
  assign valid_out = s_reg.cnt != '0;
  assign data_out = s_reg.mem[s_reg.rp];
  assign push = wr.valid && wr.ready;
  assign pop = valid_out && ready_in;

  // pointer and count update
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = wr.data;
      s_next.wp = s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = s_reg.rp + 1'b1;
    end
    case ({push, pop})
      2'b10: s_next.cnt = s_reg.cnt + 1'b1;
      2'b01: s_next.cnt = s_reg.cnt - 1'b1;
      default: s_next.cnt = s_reg.cnt;
    endcase
  end

  // state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// file: bench/blc_asserts.sv
`timescale 1ns/100ps
// ====================================================
// port checker for the calibration block
module blc_asserts (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [blc_pkg::BLC_ADDR_W-1:0] reg_addr_in,
  input wire logic [blc_pkg::BLC_DATA_W-1:0] reg_wdata_in,
  input wire logic [blc_pkg::BLC_DATA_W-1:0] reg_rdata_out,
  // pixel ports
  input wire logic pix_valid_in,
  input wire logic pix_ready_out,
  input wire logic [blc_pkg::BLC_PIX_W-1:0] pix_data_out,
  input wire logic pix_dark_out,
  input wire logic pix_valid_out,
  input wire logic pix_ready_in,
  // status
  input wire logic dark_cal_error_flags_out
);
  import blc_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic [BLC_DATA_W-1:0] lines_reg;
  logic mapped;
  // shadow of line config; skip bit only visible through writes
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lines_reg <= BLC_LINES_RST;
    end else if (reg_wr_in && reg_addr_in == BLC_ADDR_LINES) begin
      lines_reg <= reg_wdata_in;
    end
  end
  // decode of the four mapped words
  assign mapped = reg_addr_in inside {BLC_ADDR_FILT, BLC_ADDR_OFS, BLC_ADDR_ERR, BLC_ADDR_LINES};
  // ====================================================
  // properties
  property p_hold;
    pix_valid_out && !pix_ready_in |=> pix_valid_out && $stable({pix_dark_out, pix_data_out});
  endproperty
  a_hold: assert property (p_hold) else $error("stalled output word changed");
  property p_ofs_mask;
    reg_rd_in && reg_addr_in == BLC_ADDR_OFS |=> (reg_rdata_out & ~BLC_OFS_MASK) == '0;
  endproperty
  a_ofs_mask: assert property (p_ofs_mask) else $error("offset word reserved bits set");
  property p_err_read;
    reg_rd_in && reg_addr_in == BLC_ADDR_ERR |=>
      reg_rdata_out == {15'h0000, $past(dark_cal_error_flags_out)};
  endproperty
  a_err_read: assert property (p_err_read) else $error("error word differs from flag");
  property p_unmapped;
    reg_rd_in && !mapped |=> reg_rdata_out == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_push;
    pix_valid_in && pix_ready_out && !pix_valid_out && !lines_reg[BLC_SKIP_BIT] |->
      ##[1:2] pix_valid_out;
  endproperty
  a_push: assert property (p_push) else $error("accepted pixel never left");
  property p_err_calc;
    $changed(dark_cal_error_flags_out) |-> !$past(pix_ready_out) || !pix_ready_out;
  endproperty
  a_err_calc: assert property (p_err_calc) else $error("error flag moved outside calc");
  property p_wr_rd;
    reg_wr_in && reg_addr_in == BLC_ADDR_OFS ##1 reg_rd_in && reg_addr_in == BLC_ADDR_OFS
      |=> reg_rdata_out == ($past(reg_wdata_in, 2) & BLC_OFS_MASK);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("offset write not read back");
  property p_rd_hold;
    !reg_rd_in |=> $stable(reg_rdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
endmodule

bind blc_top blc_asserts blc_asserts_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .pix_valid_in(pix_valid_in),
  .pix_ready_out(pix_ready_out), .pix_data_out(pix_data_out), .pix_dark_out(pix_dark_out),
  .pix_valid_out(pix_valid_out), .pix_ready_in(pix_ready_in),
  .dark_cal_error_flags_out(dark_cal_error_flags_out));

// file: bench/blc_rx_model.sv
`timescale 1ns/100ps
// ====================================================
// image receiver on the serial side
module blc_rx_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // pixel stream from the block
  input wire logic [blc_pkg::BLC_PIX_W-1:0] pix_data_in,
  input wire logic pix_dark_in,
  input wire logic pix_valid_in,
  output logic pix_ready_out,
  // bench control
  input wire logic hold_in
);
  logic [1:0] cnt_reg;
  logic [10:0] q[$];
  // stall one cycle in four so the buffer sees back-pressure every fourth cycle
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_reg <= 2'h0;
      pix_ready_out <= 1'b0;
    end else begin
      if (pix_valid_in && pix_ready_out) q.push_back({pix_dark_in, pix_data_in});
      cnt_reg <= cnt_reg + 2'h1;
      pix_ready_out <= !hold_in && cnt_reg != 2'h3;
    end
  end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/100ps
// ====================================================
// bench for the calibration block
module tb_top;
  import blc_pkg::*;
  typedef struct {logic [15:0] ov; logic [9:0] im; logic [9:0] e0;} blc_row_s;
  logic clk_in, reset_n_in, reg_wr_in, reg_rd_in, frame_start_in, gs, hold;
  logic pix_valid_in, pix_ready_out, pix_dark_out, pix_valid_out, rdy, err_flag;
  logic [8:0] reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out, ov;
  logic [7:0] kern;
  logic [9:0] pix_data_in, pix_data_out, dkv;
  int err_count, total_checks, cyc, ex, n;
  int ofs_m[64];
  // offset word, image pixel, expected column 0 (dark base 0x010)
  blc_row_s rows[6] = '{'{16'h0001, 10'h200, 10'h1F0}, '{16'h040B, 10'h200, 10'h1F0},
    '{16'h0060, 10'h200, 10'h230}, '{16'h0460, 10'h200, 10'h1D0},
    '{16'h03FE, 10'h300, 10'h3FF}, '{16'h07FE, 10'h100, 10'h000}};

  // ====================================================
  // design and receiver
  blc_top blc_top_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .frame_start_in(frame_start_in), .global_shutter_in(gs),
    .line_kernels_in(kern), .pix_data_in(pix_data_in), .pix_valid_in(pix_valid_in),
    .pix_ready_out(pix_ready_out), .pix_data_out(pix_data_out), .pix_dark_out(pix_dark_out),
    .pix_valid_out(pix_valid_out), .pix_ready_in(rdy), .dark_cal_error_flags_out(err_flag));
  blc_rx_model blc_rx_model_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .pix_data_in(pix_data_out), .pix_dark_in(pix_dark_out), .pix_valid_in(pix_valid_out),
    .pix_ready_out(rdy), .hold_in(hold));

  // ====================================================
  // shared tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task rd(input logic [8:0] a, input logic [15:0] e);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk(reg_rdata_out, e);
  endtask
  // valid stays up between pixels; caller drops it
  task send(input logic [9:0] d);
    pix_data_in <= d;
    pix_valid_in <= 1'b1;
    @(negedge clk_in);
    while (!pix_ready_out) @(negedge clk_in);
    @(posedge clk_in);
  endtask
  // dark rows with base dkv plus column, then 64 image pixels of im
  task frame(input int nd, input int sk, input int nk, input logic [9:0] im, e0);
    int nu, m;
    logic [9:0] e;
    @(posedge clk_in);
    frame_start_in <= 1'b1;
    @(posedge clk_in);
    frame_start_in <= 1'b0;
    for (int i = 0; i < nd * nk * 64; i++) send(dkv + 10'(i % 64));
    for (int i = 0; i < 64; i++) send(im);
    pix_valid_in <= 1'b0;
    m = (nd - sk) * nk * 64;
    for (int t = 0; t < 300 && blc_rx_model_i.q.size() < m + 64; t++) @(posedge clk_in);
    nu = (nd - sk) * nk < (1 << ex) ? (nd - sk) * nk : (1 << ex);
    if (ov[0] && ov[9:1] != 9'h1FF) for (int i = 0; i < 64; i++) ofs_m[i] = ((dkv + i) * nu) >> ex;
    for (int i = 0; i < m + 64; i++) begin
      e = i < m ? dkv + 10'(i % 64) : ov[0] ? 10'(e0 + ofs_m[0] - ofs_m[i % 64]) : e0;
      chk(16'(blc_rx_model_i.q.pop_front()), {5'h00, i < m, e});
    end
    chk(16'(blc_rx_model_i.q.size()), 16'h0000);
    chk(16'(err_flag), 16'((nd - sk) * nk < (1 << ex)));
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ====================================================
  // clock and hang guard
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      summarize;
    end
  end

  // ====================================================
  // main sequence
  initial begin
    {reset_n_in, reg_wr_in, reg_rd_in, frame_start_in, gs, hold, pix_valid_in} = '0;
    reg_addr_in = '0;
    reg_wdata_in = '0;
    pix_data_in = '0;
    kern = 8'h01;
    repeat (6) @(posedge clk_in);
    chk({13'h0000, pix_valid_out, pix_ready_out, err_flag}, 16'h0002);
    chk(reg_rdata_out, 16'h0000);
    reset_n_in <= 1'b1;
    rd(BLC_ADDR_OFS, 16'h0001);
    rd(BLC_ADDR_LINES, 16'h0108);
    rd(BLC_ADDR_FILT, 16'h0300);
    rd(9'h0FF, 16'h0000);
    wr(BLC_ADDR_ERR, 16'hFFFF);
    rd(BLC_ADDR_ERR, 16'h0000);
    wr(BLC_ADDR_LINES, 16'hFFFF);
    rd(BLC_ADDR_LINES, 16'h01FF);
    // write then read in the very next cycle returns the new word
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= BLC_ADDR_OFS;
    reg_wdata_in <= 16'hF9A4;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk(reg_rdata_out, 16'h01A4);
    $display("test registers done");
    ex = 0;
    dkv = 10'h010;
    wr(BLC_ADDR_FILT, 16'h0000);
    wr(BLC_ADDR_LINES, 16'h0102);
    foreach (rows[k]) begin
      ov = rows[k].ov;
      wr(BLC_ADDR_OFS, ov);
      rd(BLC_ADDR_OFS, ov);
      frame(2, 1, 1, rows[k].im, rows[k].e0);
      $display("test row %0d done", k);
    end
    // frozen factors survive a brighter dark level, then follow it once unfrozen
    ov = 16'h03FF;
    wr(BLC_ADDR_OFS, ov);
    dkv = 10'h040;
    frame(2, 1, 1, 10'h200, 10'h1F0);
    ov = 16'h0001;
    wr(BLC_ADDR_OFS, ov);
    frame(2, 1, 1, 10'h200, 10'h1C0);
    $display("test freeze done");
    // two samples per column against four requested
    ex = 2;
    wr(BLC_ADDR_FILT, 16'h0200);
    kern <= 8'h02;
    frame(2, 1, 2, 10'h200, 10'h1E0);
    rd(BLC_ADDR_ERR, 16'h0001);
    wr(BLC_ADDR_LINES, 16'h00FF);
    frame(255, 0, 2, 10'h200, 10'h1C0);
    gs <= 1'b1;
    wr(BLC_ADDR_LINES, 16'h0001);
    frame(1, 0, 80, 10'h200, 10'h1C0);
    $display("test row counts done");
    // buffer fills to its depth while the receiver holds off
    hold <= 1'b1;
    repeat (2) @(posedge clk_in);
    pix_valid_in <= 1'b1;
    n = 0;
    repeat (20) begin
      @(negedge clk_in);
      if (pix_ready_out) n++;
      @(posedge clk_in);
    end
    pix_valid_in <= 1'b0;
    hold <= 1'b0;
    chk(16'(n), 16'h0010);
    repeat (40) @(posedge clk_in);
    chk(16'(blc_rx_model_i.q.size()), 16'h0010);
    $display("test buffer done");
    summarize;
  end
endmodule
